// ### ulpd_divisor.sv
// What this block does
// - Divisor is sixteen bits in two bytes
// - Divisor access only while latch bit set
// - Clock is serial clock over sixteen-times divisor
// - Receiver detects minimum pulses with this clock
// - Zero divisor stops clock and detection
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module ulpd_divisor
  import ulpd_pkg::*;
#(
  parameter int DIV_W = ULPD_DIV_W
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Infrared receive pin, active high pulse
  input  wire logic        ir_rx,
  // Low-power baud tick and detected pulse
  output logic             lp_baud_tick,
  output logic             lp_pulse_seen
);
  typedef struct packed {
    logic [ULPD_BYTE_W-1:0] lp_div_low_half;
    logic [ULPD_BYTE_W-1:0] lp_div_high_half;
    logic                   divisor_latch_access;
    logic [DIV_W-1:0]       div_cnt;
    logic [ULPD_OVS_W-1:0]  ovs_cnt;
    logic                   tick;
    logic                   rx_prev;
    logic [ULPD_OVS_W-1:0]  pulse_ticks;
    logic                   pulse_seen;
    logic [31:0]            rdata;
  } ulpd_state_t;

  ulpd_state_t st;
  ulpd_state_t next_st;
  logic        rx_sync;
  logic [DIV_W-1:0] divisor;
  logic        div_on;
  // Register decode and divider wrap points
  logic        hit_ctl;
  logic        hit_low;
  logic        hit_high;
  logic        wr_low_open;
  logic        wr_high_open;
  logic        rd_low_open;
  logic        div_wrap;
  logic        ovs_wrap;
  logic        rx_fall;

  ulpd_sync u_rx_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (ir_rx),
    .sync_out (rx_sync)
  );

  assign divisor = {st.lp_div_high_half, st.lp_div_low_half};
  assign div_on  = (divisor != ULPD_DIV_ZERO);
  // Full address compare, so aliases of the divisor halves stay unmapped
  assign hit_ctl      = (reg_addr == ULPD_ADDR_LINE_CTL);
  assign hit_low      = (reg_addr == ULPD_ADDR_DIV_LOW);
  assign hit_high     = (reg_addr == ULPD_ADDR_DIV_HIGH);
  assign wr_low_open  = reg_wr && st.divisor_latch_access && hit_low;
  assign wr_high_open = reg_wr && st.divisor_latch_access && hit_high;
  assign rd_low_open  = reg_rd && st.divisor_latch_access && hit_low;
  assign div_wrap     = div_on && (st.div_cnt >= divisor - DIV_W'(ULPD_DIV_ONE));
  assign ovs_wrap     = div_wrap && (st.ovs_cnt == ULPD_OVS_LAST);
  assign rx_fall      = st.rx_prev && !rx_sync;

  always_comb begin
    next_st       = st;
    next_st.tick  = 1'b0;
    next_st.rdata = '0;
    // Line control bit is always reachable, it opens the divisor window
    if (reg_wr && hit_ctl) begin
      next_st.divisor_latch_access = reg_wdata[ULPD_LATCH_BIT];
    end
    if (wr_low_open) begin
      next_st.lp_div_low_half = reg_wdata[ULPD_BYTE_W-1:0];
    end
    if (wr_high_open) begin
      next_st.lp_div_high_half = reg_wdata[ULPD_BYTE_W-1:0];
    end
    if (reg_rd) begin
      if (reg_addr == ULPD_ADDR_LINE_CTL) begin
        next_st.rdata[ULPD_LATCH_BIT] = st.divisor_latch_access;
      end else if (st.divisor_latch_access && reg_addr == ULPD_ADDR_DIV_LOW) begin
        next_st.rdata[ULPD_BYTE_W-1:0] = st.lp_div_low_half;
      end else if (st.divisor_latch_access && reg_addr == ULPD_ADDR_DIV_HIGH) begin
        next_st.rdata[ULPD_BYTE_W-1:0] = st.lp_div_high_half;
      end
    end
    if (!div_on) begin
      next_st.div_cnt = ULPD_DIV_ZERO;
      next_st.ovs_cnt = ULPD_OVS_ZERO;
    end else if (div_wrap) begin
      // The >= in the wrap test also recovers when the divisor shrinks under a running count
      next_st.div_cnt = ULPD_DIV_ZERO;
      next_st.ovs_cnt = st.ovs_cnt + ULPD_OVS_ONE;
      if (ovs_wrap) begin
        next_st.tick = 1'b1;
      end
    end else begin
      next_st.div_cnt = st.div_cnt + ULPD_DIV_ONE;
    end
    // no detection when off
    // Width saturates at fifteen ticks, a longer pulse still counts once
    next_st.rx_prev    = rx_sync;
    next_st.pulse_seen = 1'b0;
    if (!div_on || !rx_sync) begin
      next_st.pulse_ticks = ULPD_OVS_ZERO;
    end else if (st.tick && st.pulse_ticks != ULPD_OVS_LAST) begin
      next_st.pulse_ticks = st.pulse_ticks + ULPD_MIN_TICKS;
    end
    if (div_on && rx_fall && st.pulse_ticks >= ULPD_MIN_TICKS) begin
      next_st.pulse_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata     = st.rdata;
  assign lp_baud_tick  = st.tick;
  assign lp_pulse_seen = st.pulse_seen;

  // Checks
  zero_stops_tick_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !div_on |=> !lp_baud_tick) else $error("tick with zero divisor");
  zero_no_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !div_on |=> !lp_pulse_seen) else $error("pulse with zero divisor");
  closed_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && !st.divisor_latch_access) |=> $stable(divisor)) else $error("closed write changed divisor");
  closed_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && !st.divisor_latch_access && reg_addr == ULPD_ADDR_DIV_LOW) |=> reg_rdata == '0)
    else $error("closed read returned data");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reg_rdata[31:ULPD_BYTE_W] == '0) else $error("reserved bits nonzero");
  open_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && st.divisor_latch_access && reg_addr == ULPD_ADDR_DIV_HIGH)
    |=> st.lp_div_high_half == $past(reg_wdata[ULPD_BYTE_W-1:0])) else $error("high byte not stored");
  div_one_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (lp_baud_tick && divisor == ULPD_DIV_ONE && $stable(divisor)) |=> !lp_baud_tick [*8])
    else $error("tick spacing too short");
  pulse_cause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lp_pulse_seen |-> $past(st.pulse_ticks) != ULPD_OVS_ZERO) else $error("pulse too short");

  // Register bus
  latch_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && hit_ctl) |=> st.divisor_latch_access == $past(reg_wdata[ULPD_LATCH_BIT]))
    else $error("latch bit not stored");
  open_low_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_low_open |=> st.lp_div_low_half == $past(reg_wdata[ULPD_BYTE_W-1:0]))
    else $error("low byte not stored");
  open_low_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_low_open |=> reg_rdata[ULPD_BYTE_W-1:0] == $past(st.lp_div_low_half))
    else $error("low byte read wrong");
  open_high_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && st.divisor_latch_access && hit_high)
    |=> reg_rdata[ULPD_BYTE_W-1:0] == $past(st.lp_div_high_half))
    else $error("high byte read wrong");
  closed_high_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && !st.divisor_latch_access && hit_high) |=> reg_rdata == '0)
    else $error("closed high read returned data");
  idle_read_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data without a read");
  // Divider
  count_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (div_on && $stable(divisor)) |-> st.div_cnt < divisor)
    else $error("divider count out of range");
  ovs_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    div_wrap |=> st.ovs_cnt == $past(st.ovs_cnt) + ULPD_OVS_ONE)
    else $error("oversample count did not step");
  tick_single_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lp_baud_tick |=> !lp_baud_tick)
    else $error("tick longer than one cycle");
  zero_clears_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !div_on |=> (st.div_cnt == '0 && st.ovs_cnt == '0))
    else $error("divider running with zero divisor");
  // Pulse detector
  pulse_single_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lp_pulse_seen |=> !lp_pulse_seen)
    else $error("pulse flag longer than one cycle");
  pulse_on_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    lp_pulse_seen |-> ($past(st.rx_prev) && !$past(rx_sync)))
    else $error("pulse flag without falling edge");
  zero_clears_width_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !div_on |=> st.pulse_ticks == '0)
    else $error("width counted with zero divisor");
  pulse_width_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (div_on && rx_sync && !st.tick) |=> st.pulse_ticks == $past(st.pulse_ticks))
    else $error("width moved without a tick");
  pulse_width_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (div_on && rx_sync && st.tick && st.pulse_ticks != ULPD_OVS_LAST)
    |=> st.pulse_ticks == $past(st.pulse_ticks) + ULPD_MIN_TICKS)
    else $error("width missed a tick");
endmodule : ulpd_divisor

// ### ulpd_pkg.sv
package ulpd_pkg;
  // Register byte addresses (printed offsets are multiples of four)
  localparam logic [31:0] ULPD_ADDR_DIV_LOW  = 32'h5000_1120;
  localparam logic [31:0] ULPD_ADDR_DIV_HIGH = 32'h5000_1124;
  // Own control register holding the divisor-latch access bit
  localparam logic [31:0] ULPD_ADDR_LINE_CTL = 32'h5000_1180;
  localparam int          ULPD_LATCH_BIT     = 7;
  localparam int          ULPD_BYTE_W        = 8;
  localparam int          ULPD_REG_W         = 16;
  localparam int          ULPD_DIV_W         = 16;
  localparam int          ULPD_OVS_W         = 4;
  localparam logic [7:0]  ULPD_BYTE_RESET    = 8'h00;
  localparam logic [15:0] ULPD_DIV_ZERO      = 16'h0000;
  localparam logic [15:0] ULPD_DIV_ONE       = 16'h0001;
  localparam logic [3:0]  ULPD_OVS_LAST      = 4'hf;
  localparam logic [3:0]  ULPD_OVS_ZERO      = 4'h0;
  localparam logic [3:0]  ULPD_OVS_ONE       = 4'h1;
  // Shortest accepted pulse, in low-power baud ticks
  localparam logic [3:0]  ULPD_MIN_TICKS     = 4'h1;
endpackage : ulpd_pkg

// ### ulpd_sync.sv
`timescale 1ns/1ns
module ulpd_sync
  import ulpd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } ulpd_sync_t;
  ulpd_sync_t st;
  ulpd_sync_t next_st;

  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule : ulpd_sync

// ### ulpd_ir_model.sv
`timescale 1ns/1ns
module ulpd_ir_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Pulse request from the bench
  input  wire logic        send,
  input  wire logic [15:0] pw,
  // Infrared line, idles low between pulses
  output logic             ir_rx
);
  logic [15:0] left;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      left <= 16'h0000;
    end else if (send) begin
      left <= pw;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
  assign ir_rx = (left != 16'h0000);
endmodule : ulpd_ir_model

// ### uart_low_power_ir_baud_divisor_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module uart_low_power_ir_baud_divisor_tb
  import ulpd_pkg::*;
;
  logic        clk_sys, sys_rst, reg_wr, reg_rd, ir_rx, lp_baud_tick, lp_pulse_seen, send;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] pw;
  int          error_cnt, num_checks, n;
  ulpd_divisor DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ir_rx(ir_rx),
    .lp_baud_tick(lp_baud_tick), .lp_pulse_seen(lp_pulse_seen));
  ulpd_ir_model ir (.clk_sys(clk_sys), .sys_rst(sys_rst), .send(send), .pw(pw), .ir_rx(ir_rx));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys); reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk_sys); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys); reg_rd <= 1'b0; #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  // Latch bit set first, as software must
  task set_div(input logic [15:0] v);
    wr(ULPD_ADDR_LINE_CTL, 32'h0000_0080);
    wr(ULPD_ADDR_DIV_LOW, {24'h00_0000, v[7:0]});
    wr(ULPD_ADDR_DIV_HIGH, {24'h00_0000, v[15:8]});
    repeat (8) @(posedge clk_sys);
  endtask : set_div
  task wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (lp_baud_tick !== 1'b1 && c < 5000);
  endtask : wait_tick
  task pulse(input logic [15:0] w);
    @(posedge clk_sys); send <= 1'b1; pw <= w;
    @(posedge clk_sys); send <= 1'b0;
  endtask : pulse
  task t_regs;
    rd(ULPD_ADDR_DIV_LOW, 32'h0000_0000);
    wr(ULPD_ADDR_DIV_LOW, 32'hffff_ff5a);
    wr(ULPD_ADDR_LINE_CTL, 32'h0000_0080);
    rd(ULPD_ADDR_LINE_CTL, 32'h0000_0080);
    rd(ULPD_ADDR_DIV_LOW, 32'h0000_0000);
    wr(ULPD_ADDR_DIV_LOW, 32'hffff_ffa5);
    wr(ULPD_ADDR_DIV_HIGH, 32'hffff_ff3c);
    rd(ULPD_ADDR_DIV_LOW, 32'h0000_00a5);
    rd(ULPD_ADDR_DIV_HIGH, 32'h0000_003c);
    rd(32'h5000_1128, 32'h0000_0000);
    wr(ULPD_ADDR_LINE_CTL, 32'h0000_0000);
    rd(ULPD_ADDR_LINE_CTL, 32'h0000_0000);
    rd(ULPD_ADDR_DIV_HIGH, 32'h0000_0000);
    wr(ULPD_ADDR_DIV_HIGH, 32'h0000_0011);
    wr(ULPD_ADDR_LINE_CTL, 32'h0000_0080);
    rd(ULPD_ADDR_DIV_HIGH, 32'h0000_003c);
    $display("test regs done");
  endtask : t_regs
  task t_tick;
    set_div(16'h0002);
    wait_tick(n);
    wait_tick(n);
    `CHK("tick gap", 32, n)
    // Divisor 0x0088 gives about 115.2K at the 250 MHz serial clock
    set_div(16'h0088);
    wait_tick(n);
    wait_tick(n);
    `CHK("tick gap", 2176, n)
    set_div(16'h0101);
    wait_tick(n);
    wait_tick(n);
    `CHK("tick gap", 4112, n)
    $display("test tick done");
  endtask : t_tick
  task t_zero;
    set_div(16'h0000); pulse(16'h0030); n = 0;
    repeat (200) begin @(posedge clk_sys); n += (lp_baud_tick !== 1'b0) + (lp_pulse_seen !== 1'b0); end
    `CHK("idle activity", 0, n)
    $display("test zero done");
  endtask : t_zero
  task t_pulse;
    set_div(16'h0001); pulse(16'h0030); n = 0;
    repeat (90) begin @(posedge clk_sys); n += (lp_pulse_seen === 1'b1); end
    `CHK("pulse seen", 1, n)
    // Starting right after a tick, a four-cycle pulse spans no tick
    wait_tick(n);
    pulse(16'h0004);
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      n += (lp_pulse_seen === 1'b1);
    end
    `CHK("short pulse", 0, n)
    $display("test pulse done");
  endtask : t_pulse
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    give_verdict;
  end
  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; send = 1'b0; pw = 16'h0000;
    reg_addr = 32'h0000_0000; reg_wdata = 32'h0000_0000; error_cnt = 0; num_checks = 0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs; t_tick; t_zero; t_pulse;
    give_verdict;
  end
endmodule : uart_low_power_ir_baud_divisor_tb
